/* File: verilog/epm_pkg.sv */
// Shared constants and types for the encoder position plausibility monitor
`default_nettype none
package epm_pkg;
  // Angles: 16-bit, one full period = 65536 counts, about 182 counts per degree
  localparam int unsigned ANG_W        = 16;
  localparam int unsigned CNT_PER_DEG  = 182;
  localparam int unsigned CD_MECH_DEG  = 15;
  localparam int unsigned ELEC_DEG     = 60;
  localparam int unsigned ZM_MECH_DEG  = 18;
  localparam logic [15:0] LIM_CD_MECH  = 16'(CD_MECH_DEG * CNT_PER_DEG);
  localparam logic [15:0] LIM_ELEC     = 16'(ELEC_DEG * CNT_PER_DEG);
  localparam logic [15:0] LIM_ZM_MECH  = 16'(ZM_MECH_DEG * CNT_PER_DEG);

  // Positions in quadrants, four per encoder pulse
  localparam int unsigned POS_W        = 32;
  localparam int unsigned QUAD_PER_PLS = 4;
  localparam int unsigned OTHER_PLS    = 15;
  localparam logic [31:0] QUAD_LIM_MIN = 32'h0000_0002;
  localparam logic [31:0] QUAD_LIM_OTH = 32'(OTHER_PLS * QUAD_PER_PLS);

  // Encoder status/fault word layout
  localparam logic [31:0] ST_SAFE_MASK = 32'h0080_0003;
  localparam logic [31:0] ST_HW_MASK   = 32'h0000_FFC0;
  localparam logic [31:0] ST_SGL_MASK  = 32'h033F_0000;
  localparam logic [31:0] ST_MLT_MASK  = 32'h7C00_0000;
  localparam int unsigned ST_TEMP_BIT  = 22;
  localparam int unsigned ST_SAFE1_BIT = 0;
  localparam int unsigned ST_SAFE2_BIT = 1;
  localparam int unsigned ST_SAFE3_BIT = 23;

  // Latched fault vector positions
  localparam int unsigned FI_CF   = 0;
  localparam int unsigned FI_ZM   = 1;
  localparam int unsigned FI_IA   = 2;
  localparam int unsigned FI_ST   = 3;
  localparam int unsigned FI_MT   = 4;
  localparam int unsigned FI_HW   = 5;
  localparam int unsigned FI_TMP  = 6;
  localparam int unsigned NUM_FLT = 7;

  typedef enum logic [1:0] {
    INIT_CD    = 2'h0,
    INIT_HALL  = 2'h1,
    INIT_IDENT = 2'h2
  } epm_init_type;

  typedef enum logic [3:0] {
    ZS_IDLE = 4'h1,
    ZS_SEEK = 4'h2,
    ZS_SYNC = 4'h4,
    ZS_FAIL = 4'h8
  } epm_zs_type;
endpackage
`default_nettype wire

/* File: verilog/epm_status_dec.sv */
// Decoder of the encoder status/fault word into fault groups
`default_nettype none
module epm_status_dec
  import epm_pkg::*;
(
  input  wire logic        sys_clk,     // System clock
  input  wire logic        rst_b,       // Async reset, active low
  input  wire logic        status_stb,  // New status word present
  input  wire logic [31:0] status_word, // Encoder status/fault word
  input  wire logic        serial_enc,  // Serial absolute encoder fitted
  output logic             st_hit,      // Singleturn group pulse
  output logic             mt_hit,      // Multiturn group pulse
  output logic             hw_hit,      // Hardware group pulse
  output logic             temp_hit,    // Over-temperature pulse
  output logic [2:0]       safety_q,    // Safety status display bits
  output logic [31:0]      word_q       // Last status word
);
  logic [31:0] grp_st;
  logic [31:0] grp_mt;
  logic [31:0] grp_hw;

  // Per-bit routing; bits 2 to 5, the safety bits, bit 22 (temperature) and bit 31 sit in no group
  genvar b;
  for (b = 0; b < 32; b++) begin : g_route
    assign grp_st[b] = ST_SGL_MASK[b] & status_word[b];
    assign grp_mt[b] = ST_MLT_MASK[b] & status_word[b];
    assign grp_hw[b] = ST_HW_MASK[b] & status_word[b] & serial_enc;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_hit   <= 1'b0;
      mt_hit   <= 1'b0;
      hw_hit   <= 1'b0;
      temp_hit <= 1'b0;
      safety_q <= 3'h0;
      word_q   <= 32'h0000_0000;
    end else begin
      st_hit   <= status_stb & (|grp_st);
      mt_hit   <= status_stb & (|grp_mt);
      hw_hit   <= status_stb & (|grp_hw);
      temp_hit <= status_stb & status_word[ST_TEMP_BIT];
      if (status_stb) begin
        safety_q <= {status_word[ST_SAFE3_BIT], status_word[ST_SAFE2_BIT],
                     status_word[ST_SAFE1_BIT]};
        word_q   <= status_word;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/epm_monitor.sv */
// Encoder position plausibility monitor: deviation, zero-mark and status checks
`default_nettype none
module epm_monitor
  import epm_pkg::*;
(
  input  wire logic        sys_clk,          // System clock, 10 MHz
  input  wire logic        rst_b,            // Async reset, active low
  input  wire logic        sample_stb,       // Position sampling cycle pulse
  input  wire logic        fault_ack,        // Pulse-inhibit acknowledge pulse
  input  wire logic        coarse_hall_sel,  // Coarse position from Hall signals
  input  wire logic        dist_coded,       // Distance-coded zero marks
  input  wire logic        abs_enc,          // Absolute encoder fitted
  input  wire logic        serial_enc,       // Serial absolute encoder
  input  wire logic [1:0]  init_src,         // Pole position init source
  input  wire logic        pole_init_done,   // Coarse pole init complete
  input  wire logic [15:0] cd_mech_ang,      // Track C/D mechanical angle
  input  wire logic [15:0] cd_elec_ang,      // Track C/D electrical angle
  input  wire logic [15:0] hall_elec_ang,    // Hall electrical angle
  input  wire logic [15:0] fine_mech_ang,    // A/B mechanical angle
  input  wire logic [15:0] fine_elec_ang,    // A/B electrical angle
  input  wire logic        zero_mark_stb,    // Zero mark passed pulse
  input  wire logic [15:0] zm_exp_mech,      // Expected mark mech angle
  input  wire logic [15:0] zm_exp_elec,      // Expected mark elec angle
  input  wire logic [31:0] incr_pos,         // Incremental position, quadrants
  input  wire logic        abs_stb,          // Absolute position read pulse
  input  wire logic [31:0] abs_pos,          // Absolute position, quadrants
  input  wire logic [31:0] enc_dev_limit,    // Limit supplied by encoder
  input  wire logic [31:0] zm_spacing,       // Equidistant mark spacing
  input  wire logic [31:0] zm_pair_offset,   // Expected coded pair distance
  input  wire logic        status_stb,       // Status word valid pulse
  input  wire logic [31:0] status_word,      // Encoder status/fault word
  output logic             coarse_fine_deviation_fault, // Latched
  output logic             coarse_fine_deviation_alarm, // Per sample
  output logic             zero_mark_window_fault,      // Latched
  output logic             incr_abs_deviation_fault,    // Latched
  output logic             singleturn_position_fault,   // Latched
  output logic             multiturn_fault_group,       // Latched
  output logic             encoder_hw_fault_group,      // Latched
  output logic             encoder_temperature_fault,   // Latched
  output logic             safety_status_one,           // Status bit 0
  output logic             safety_status_two,           // Status bit 1
  output logic             safety_status_pos2,          // Status bit 23
  output logic             fine_sync_done,              // Fine sync held
  output logic             abs_pos_accept,              // Accept pulse
  output logic [31:0]      abs_pos_q,                   // Last accepted position
  output logic [31:0]      fault_value_word             // Value of newest fault
);
  function automatic logic [15:0] mag16(input logic [15:0] v);
    mag16 = v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? 32'(-v) : v;
  endfunction

  epm_zs_type          zs_q;
  epm_zs_type          zs_d;
  logic [NUM_FLT-1:0]  lat_q;
  logic [NUM_FLT-1:0]  lat_set;
  logic                alarm_q;
  logic                zm_seen_q;
  logic                zr_valid_q;
  logic                pair_q;
  logic [31:0]         zr_q;
  logic [31:0]         fv_q;
  logic [31:0]         fv_d;
  logic                acc_q;
  logic [31:0]         absq_q;

  // Coarse/fine deviation; wraparound subtraction keeps one period = 360 deg
  logic [15:0] cd_mech_dev;
  logic [15:0] cd_elec_dev;
  logic [15:0] hall_dev;
  logic        cd_err;
  logic        hall_err;
  logic        cf_err;
  logic [15:0] cf_dev;
  logic        synced;

  assign cd_mech_dev = cd_mech_ang - fine_mech_ang;
  assign cd_elec_dev = cd_elec_ang - fine_elec_ang;
  assign hall_dev    = hall_elec_ang - fine_elec_ang;
  assign cd_err      = (mag16(cd_mech_dev) > LIM_CD_MECH) ||
                       (mag16(cd_elec_dev) > LIM_ELEC);
  assign hall_err    = mag16(hall_dev) > LIM_ELEC;
  assign cf_err      = coarse_hall_sel ? hall_err : cd_err;
  assign cf_dev      = coarse_hall_sel ? hall_dev : cd_mech_dev;
  assign synced      = (zs_q == ZS_SYNC);

  // Zero-mark check after coarse pole initialisation
  logic [15:0] zm_mech_dev;
  logic [15:0] zm_elec_dev;
  logic        zm_ready;
  logic        zm_check;
  logic        zm_bad;

  assign zm_mech_dev = fine_mech_ang - zm_exp_mech;
  assign zm_elec_dev = fine_elec_ang - zm_exp_elec;
  assign zm_ready    = !dist_coded || zm_seen_q;
  assign zm_check    = zero_mark_stb && (zs_q == ZS_SEEK) && zm_ready;
  assign zm_bad      = (init_src == INIT_CD) ?
                       (mag16(zm_mech_dev) > LIM_ZM_MECH) :
                       (mag16(zm_elec_dev) > LIM_ELEC);

  // Incremental against absolute position
  logic [31:0] abs_diff;
  logic [31:0] ia_lim;
  logic        abs_evt;
  logic        abs_bad;

  assign abs_diff = abs_pos - incr_pos;
  assign ia_lim   = !serial_enc ? QUAD_LIM_OTH :
                    (enc_dev_limit < QUAD_LIM_MIN) ? QUAD_LIM_MIN :
                    enc_dev_limit;
  assign abs_evt  = abs_stb && abs_enc;
  assign abs_bad  = abs_evt && (mag32(abs_diff) > ia_lim);

  // Zero-mark spacing for incremental encoders
  logic [31:0] zr_diff;
  logic [31:0] zr_rem;
  logic        zi_evt;
  logic        zi_pair;
  logic        zi_take;
  logic        zi_bad;
  logic [31:0] zi_dev;

  assign zr_diff = incr_pos - zr_q;
  // A zero spacing means the spacing is unknown, so equidistant marks are not checked
  assign zr_rem  = (zm_spacing == 32'h0000_0000) ? 32'h0000_0000 :
                   (mag32(zr_diff) % zm_spacing);
  assign zi_evt  = zero_mark_stb && !abs_enc;
  assign zi_pair = !dist_coded || pair_q;
  assign zi_take = zi_evt && zi_pair && !zr_valid_q;
  assign zi_bad  = zi_evt && zi_pair && zr_valid_q &&
                   (dist_coded ? (zr_diff != zm_pair_offset) :
                    (zr_rem != 32'h0000_0000));
  assign zi_dev  = dist_coded ? (zr_diff - zm_pair_offset) : zr_rem;

  // Status word decoder
  logic       st_hit;
  logic       mt_hit;
  logic       hw_hit;
  logic       temp_hit;
  logic [2:0] safety_q;
  logic [31:0] st_word_q;

  epm_status_dec u_dec (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .status_stb  (status_stb),
    .status_word (status_word),
    .serial_enc  (serial_enc),
    .st_hit      (st_hit),
    .mt_hit      (mt_hit),
    .hw_hit      (hw_hit),
    .temp_hit    (temp_hit),
    .safety_q    (safety_q),
    .word_q      (st_word_q)
  );

  // Fault set terms; the coarse check only counts in a sampling cycle
  assign lat_set[FI_CF]  = sample_stb && cf_err && !synced;
  assign lat_set[FI_ZM]  = zm_check && zm_bad;
  assign lat_set[FI_IA]  = abs_bad || zi_bad;
  assign lat_set[FI_ST]  = st_hit;
  assign lat_set[FI_MT]  = mt_hit;
  assign lat_set[FI_HW]  = hw_hit;
  assign lat_set[FI_TMP] = temp_hit;

  // Newest fault's value wins; simultaneous sets resolve by this order
  assign fv_d = lat_set[FI_CF] ? {{16{cf_dev[15]}}, cf_dev} :
                lat_set[FI_ZM] ? {fine_mech_ang, zm_elec_dev} :
                abs_bad        ? abs_diff :
                zi_bad         ? zi_dev :
                (|lat_set[FI_TMP:FI_ST]) ? st_word_q :
                fv_q;

  always_comb begin
    zs_d = zs_q;
    case (zs_q)
      ZS_IDLE: if (pole_init_done) zs_d = ZS_SEEK;
      ZS_SEEK: begin
        if (!pole_init_done) begin
          zs_d = ZS_IDLE;
        end else if (zm_check) begin
          zs_d = zm_bad ? ZS_FAIL : ZS_SYNC;
        end
      end
      ZS_SYNC: if (!pole_init_done) zs_d = ZS_IDLE;
      ZS_FAIL: if (!pole_init_done) zs_d = ZS_IDLE;
      default: zs_d = ZS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      zs_q <= ZS_IDLE;
    end else begin
      zs_q <= zs_d;
    end
  end

  // First mark of a coded encoder only arms the check
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      zm_seen_q <= 1'b0;
    end else if (zs_q != ZS_SEEK) begin
      zm_seen_q <= 1'b0;
    end else if (zero_mark_stb) begin
      zm_seen_q <= 1'b1;
    end
  end

  // Set wins over acknowledge in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_q <= '0;
    end else begin
      lat_q <= lat_set | (lat_q & ~{NUM_FLT{fault_ack}});
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_q <= 1'b0;
    end else if (sample_stb) begin
      alarm_q <= cf_err && synced;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fv_q <= 32'h0000_0000;
    end else begin
      fv_q <= fv_d;
    end
  end

  // A rejected absolute read never reaches the accepted position
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q  <= 1'b0;
      absq_q <= 32'h0000_0000;
    end else begin
      acc_q <= abs_evt && !abs_bad;
      if (abs_evt && !abs_bad) begin
        absq_q <= abs_pos;
      end
    end
  end

  // Reference mark (or pair) stays until reset; pair_q marks the second mark
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      zr_valid_q <= 1'b0;
      pair_q     <= 1'b0;
      zr_q       <= 32'h0000_0000;
    end else begin
      if (zi_evt && dist_coded) begin
        pair_q <= !pair_q;
      end
      if (zi_take) begin
        zr_valid_q <= 1'b1;
        zr_q       <= incr_pos;
      end
    end
  end

  assign coarse_fine_deviation_fault = lat_q[FI_CF];
  assign coarse_fine_deviation_alarm = alarm_q;
  assign zero_mark_window_fault      = lat_q[FI_ZM];
  assign incr_abs_deviation_fault    = lat_q[FI_IA];
  assign singleturn_position_fault   = lat_q[FI_ST];
  assign multiturn_fault_group       = lat_q[FI_MT];
  assign encoder_hw_fault_group      = lat_q[FI_HW];
  assign encoder_temperature_fault   = lat_q[FI_TMP];
  assign safety_status_one           = safety_q[0];
  assign safety_status_two           = safety_q[1];
  assign safety_status_pos2          = safety_q[2];
  assign fine_sync_done              = synced;
  assign abs_pos_accept              = acc_q;
  assign abs_pos_q                   = absq_q;
  assign fault_value_word            = fv_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_cd_fault;
    sample_stb && !coarse_hall_sel && !synced && (mag16(cd_mech_dev) > LIM_CD_MECH)
      |=> coarse_fine_deviation_fault;
  endproperty
  a_cd_fault: assert property (p_cd_fault) else $error("C/D deviation fault missed");

  property p_hall_fault;
    sample_stb && coarse_hall_sel && !synced && (mag16(hall_dev) > LIM_ELEC)
      |=> coarse_fine_deviation_fault && (fault_value_word[15:0] == $past(hall_dev));
  endproperty
  a_hall_fault: assert property (p_hall_fault) else $error("Hall deviation fault or value wrong");

  property p_alarm;
    sample_stb && synced && cf_err && !coarse_fine_deviation_fault
      |=> coarse_fine_deviation_alarm && !coarse_fine_deviation_fault;
  endproperty
  a_alarm: assert property (p_alarm) else $error("Synced deviation must alarm only");

  property p_cd_value;
    lat_set[FI_CF] && !coarse_hall_sel |=> fault_value_word == {{16{$past(cd_mech_dev[15])}}, $past(cd_mech_dev)};
  endproperty
  a_cd_value: assert property (p_cd_value) else $error("C/D fault value wrong");

  property p_zm_fail;
    zm_check && zm_bad |=> zero_mark_window_fault && !fine_sync_done
      ##1 !fine_sync_done;
  endproperty
  a_zm_fail: assert property (p_zm_fail) else $error("Failed zero mark reached sync");

  property p_zm_value;
    zm_check && zm_bad |=> fault_value_word == {$past(fine_mech_ang), $past(zm_elec_dev)};
  endproperty
  a_zm_value: assert property (p_zm_value) else $error("Zero-mark value wrong");

  property p_abs_reject;
    abs_evt && (mag32(abs_diff) > ia_lim) |=> incr_abs_deviation_fault && !abs_pos_accept && $stable(abs_pos_q);
  endproperty
  a_abs_reject: assert property (p_abs_reject) else $error("Bad absolute read not rejected");

  property p_serial_min;
    abs_evt && serial_enc && (mag32(abs_diff) <= QUAD_LIM_MIN) |=> abs_pos_accept;
  endproperty
  a_serial_min: assert property (p_serial_min) else $error("Serial limit below two quadrants");

  property p_other_lim;
    abs_evt && !serial_enc && (mag32(abs_diff) > QUAD_LIM_OTH) |=> !abs_pos_accept;
  endproperty
  a_other_lim: assert property (p_other_lim) else $error("Fixed limit not applied");

  property p_safety_only;
    status_stb && ((status_word & ~ST_SAFE_MASK) == 32'h0000_0000) |-> ##2 !$rose(singleturn_position_fault);
  endproperty
  a_safety_only: assert property (p_safety_only) else $error("Safety bits raised a fault");

  property p_single;
    status_stb && (|(status_word & ST_SGL_MASK)) |-> ##2 singleturn_position_fault;
  endproperty
  a_single: assert property (p_single) else $error("Singleturn group not raised");

  property p_latch;
    coarse_fine_deviation_fault && !fault_ack |=> coarse_fine_deviation_fault;
  endproperty
  a_latch: assert property (p_latch) else $error("Fault dropped without acknowledge");

  c_sync: cover property (zm_check && !zm_bad ##1 fine_sync_done);
  c_alarm: cover property (coarse_fine_deviation_alarm);
  c_abs_ok: cover property (abs_pos_accept);
  c_coded_bad: cover property (zi_bad && dist_coded);
endmodule
`default_nettype wire

/* File: dv/epm_enc_model.sv */
// Behavioural encoder model that hands out its status/fault word on request
`default_nettype none
module epm_enc_model (
  input  wire logic        sys_clk,     // System clock
  input  wire logic        send,        // Bench asks for a word
  input  wire logic [31:0] word,        // Word to hand out
  output logic             status_stb,  // Word valid pulse
  output logic [31:0]      status_word  // Status/fault word
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    status_stb = 1'b0;
    status_word = 32'h0;
  end
  // Between strobes the word keeps toggling, so a stale copy matches only on every second cycle
  always @(posedge sys_clk) begin
    status_stb <= send;
    status_word <= send ? word : ~status_word;
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench of the encoder position plausibility monitor
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, rst_b, sample_stb, fault_ack, coarse_hall_sel, dist_coded, abs_enc, serial_enc;
  logic        pole_init_done, zero_mark_stb, abs_stb, send, status_stb;
  logic [1:0]  init_src;
  logic [15:0] cd_mech_ang, cd_elec_ang, hall_elec_ang, fine_mech_ang, fine_elec_ang, zm_exp_mech, zm_exp_elec;
  logic [31:0] incr_pos, abs_pos, enc_dev_limit, zm_spacing, zm_pair_offset, word, status_word, apq, fvw;
  logic        cf_f, cf_a, zm_f, ia_f, st_f, mt_f, hw_f, tp_f, s1, s2, s3, fsd, acc;
  int          errors, n_checks;

  epm_enc_model i_epm_enc_model (.sys_clk, .send, .word, .status_stb, .status_word);
  epm_monitor i_epm_monitor (.sys_clk, .rst_b, .sample_stb, .fault_ack, .coarse_hall_sel, .dist_coded,
    .abs_enc, .serial_enc, .init_src, .pole_init_done, .cd_mech_ang, .cd_elec_ang, .hall_elec_ang,
    .fine_mech_ang, .fine_elec_ang, .zero_mark_stb, .zm_exp_mech, .zm_exp_elec, .incr_pos, .abs_stb,
    .abs_pos, .enc_dev_limit, .zm_spacing, .zm_pair_offset, .status_stb, .status_word,
    .coarse_fine_deviation_fault(cf_f), .coarse_fine_deviation_alarm(cf_a), .zero_mark_window_fault(zm_f),
    .incr_abs_deviation_fault(ia_f), .singleturn_position_fault(st_f), .multiturn_fault_group(mt_f),
    .encoder_hw_fault_group(hw_f), .encoder_temperature_fault(tp_f), .safety_status_one(s1),
    .safety_status_two(s2), .safety_status_pos2(s3), .fine_sync_done(fsd), .abs_pos_accept(acc),
    .abs_pos_q(apq), .fault_value_word(fvw));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic go();
    @(posedge sys_clk);
  endtask

  // Caller sits on a rising edge; the strobe is taken at the next one
  task automatic samp();
    sample_stb <= 1'b1;
    go();
    sample_stb <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic ack();
    go();
    fault_ack <= 1'b1;
    go();
    fault_ack <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic t_cf();
    go();
    fine_mech_ang <= 16'hF800;
    cd_mech_ang <= 16'h02AA;
    samp();
    check("cf_wrap_edge", cf_f, 1'b0);
    go();
    cd_mech_ang <= 16'hF800 - 16'h0AAB;
    samp();
    check("cf_mech", cf_f, 1'b1);
    check("cf_value", fvw, 32'hFFFF_F555);
    repeat (4) go();
    @(negedge sys_clk);
    check("cf_latched", cf_f, 1'b1);
    ack();
    check("cf_ack", cf_f, 1'b0);
    go();
    cd_mech_ang <= 16'hF800;
    cd_elec_ang <= 16'h2AA9;
    samp();
    check("cf_elec", cf_f, 1'b1);
    ack();
    go();
    cd_elec_ang <= 16'h0;
    coarse_hall_sel <= 1'b1;
    hall_elec_ang <= 16'h2AA8;
    samp();
    check("hall_edge", cf_f, 1'b0);
    go();
    hall_elec_ang <= 16'h2AA9;
    samp();
    check("hall_fault", cf_f, 1'b1);
    check("hall_value", fvw, 32'h0000_2AA9);
    ack();
    $display("Test coarse_fine done");
  endtask

  task automatic t_zm();
    go();
    coarse_hall_sel <= 1'b0;
    hall_elec_ang <= 16'h0;
    cd_mech_ang <= 16'h2000;
    fine_mech_ang <= 16'h2000;
    zm_exp_mech <= 16'h2CCC;
    pole_init_done <= 1'b1;
    repeat (2) go();
    zero_mark_stb <= 1'b1;
    go();
    zero_mark_stb <= 1'b0;
    @(negedge sys_clk);
    check("zm_pass_sync", fsd, 1'b1);
    check("zm_pass_flt", zm_f, 1'b0);
    go();
    cd_mech_ang <= 16'h2000 + 16'h0AAB;
    samp();
    check("synced_alarm", cf_a, 1'b1);
    check("synced_fault", cf_f, 1'b0);
    go();
    cd_mech_ang <= 16'h2000;
    pole_init_done <= 1'b0;
    repeat (2) go();
    pole_init_done <= 1'b1;
    init_src <= 2'h1;
    fine_elec_ang <= 16'h3000;
    cd_elec_ang <= 16'h3000;
    zm_exp_elec <= 16'h3000 - 16'h2AA9;
    repeat (2) go();
    zero_mark_stb <= 1'b1;
    go();
    zero_mark_stb <= 1'b0;
    @(negedge sys_clk);
    check("zm_fail", zm_f, 1'b1);
    check("zm_nosync", fsd, 1'b0);
    check("zm_value", fvw, 32'h2000_2AA9);
    ack();
    $display("Test zero_mark done");
  endtask

  task automatic t_abs();
    logic [31:0] ap [4] = '{32'h13C, 32'h13D, 32'h103, 32'h110};
    logic        sr [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic        ef [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    go();
    pole_init_done <= 1'b0;
    abs_enc <= 1'b1;
    incr_pos <= 32'h100;
    for (int i = 0; i < 4; i++) begin
      go();
      fault_ack <= 1'b1;
      abs_stb <= 1'b1;
      serial_enc <= sr[i];
      enc_dev_limit <= (i == 3) ? 32'h10 : 32'h0;
      abs_pos <= ap[i];
      go();
      fault_ack <= 1'b0;
      abs_stb <= 1'b0;
      @(negedge sys_clk);
      check("abs_fault", ia_f, ef[i]);
      check("abs_accept", acc, !ef[i]);
      if (ef[i]) check("abs_value", fvw, ap[i] - 32'h100);
      else check("abs_pos_q", apq, ap[i]);
    end
    $display("Test absolute done");
  endtask

  task automatic t_st();
    logic f;
    go();
    serial_enc <= 1'b1;
    abs_enc <= 1'b0;
    for (int b = 0; b < 32; b++) begin
      go();
      fault_ack <= 1'b1;
      send <= 1'b1;
      word <= 32'h1 << b;
      go();
      fault_ack <= 1'b0;
      send <= 1'b0;
      repeat (3) go();
      @(negedge sys_clk);
      f = b inside {[6:22], [24:30]};
      check("st_grp", st_f, b inside {[16:21], 24, 25});
      check("mt_grp", mt_f, b inside {[26:30]});
      check("hw_grp", hw_f, b inside {[6:15]});
      check("temp", tp_f, b == 22);
      check("safety", {s3, s2, s1}, {b == 23, b == 1, b == 0});
      if (f) check("st_value", fvw, 32'h1 << b);
    end
    $display("Test status_word done");
  endtask

  // Mid-run reset, held for one edge; also drops the zero-mark reference
  task automatic rst();
    go();
    rst_b <= 1'b0;
    go();
    rst_b <= 1'b1;
    @(negedge sys_clk);
  endtask

  task automatic mark(input logic [31:0] pos);
    go();
    incr_pos <= pos;
    zero_mark_stb <= 1'b1;
    go();
    zero_mark_stb <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic t_inc();
    rst();
    check("rst_apq", apq, 32'h0);
    check("rst_fvw", fvw, 32'h0);
    go();
    zm_spacing <= 32'h40;
    mark(32'h100);
    mark(32'h180);
    check("zi_equi_ok", ia_f, 1'b0);
    mark(32'h1C5);
    check("zi_equi_bad", ia_f, 1'b1);
    check("zi_equi_val", fvw, 32'h5);
    rst();
    go();
    dist_coded <= 1'b1;
    zm_pair_offset <= 32'h300;
    pole_init_done <= 1'b1;
    init_src <= 2'h2;
    mark(32'h100);
    check("zm_coded_first", {zm_f, fsd}, 2'b00);
    mark(32'h140);
    check("zm_coded_second", zm_f, 1'b1);
    check("zm_coded_nosync", fsd, 1'b0);
    mark(32'h400);
    mark(32'h440);
    check("zi_pair_ok", ia_f, 1'b0);
    mark(32'h800);
    mark(32'h844);
    check("zi_pair_bad", ia_f, 1'b1);
    check("zi_pair_val", fvw, 32'h404);
    check("zm_still_nosync", fsd, 1'b0);
    ack();
    $display("Test incr_marks done");
  endtask

  initial begin
    {rst_b, sample_stb, fault_ack, coarse_hall_sel, dist_coded, abs_enc, serial_enc} = '0;
    {pole_init_done, zero_mark_stb, abs_stb, send, init_src} = '0;
    {cd_mech_ang, cd_elec_ang, hall_elec_ang, fine_mech_ang, fine_elec_ang, zm_exp_mech, zm_exp_elec} = '0;
    {incr_pos, abs_pos, enc_dev_limit, zm_spacing, zm_pair_offset, word} = '0;
    errors = 0;
    n_checks = 0;
    repeat (3) go();
    rst_b <= 1'b1;
    @(negedge sys_clk);
    check("rst_cf", cf_f, 1'b0);
    check("rst_value", fvw, 32'h0);
    t_cf();
    t_zm();
    t_abs();
    t_st();
    t_inc();
    end_of_test();
  end

  // Whole run takes well under a thousand cycles
  initial begin
    #200_000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
